/* File: design/dsp_pkg.sv */
// Constants and carrier types for the distributor stream ports
package dsp_pkg;

    // ==========================================================
    // Stream widths, build-time configuration
    // ==========================================================
    localparam int TS_TX_W   = 64; // Distributor to translation service
    localparam int TS_RX_W   = 64; // Translation service to distributor
    localparam int MSG16_W   = 16; // Wake-request and collator links
    localparam int BYTE_W    = 8;  // Bits covered by one keep bit
    localparam int TS_DEST_W = 2;  // Translation-service selector
    localparam int TS_ID_W   = 2;  // Translation-service source id
    localparam int CO_DEST_W = 3;  // Collator selector
    localparam int CO_ID_W   = 3;  // Collator source id

    // ==========================================================
    // Buffer depths and build options
    // ==========================================================
    localparam int TX_DEPTH  = 8;  // Outgoing translation-service buffer
    localparam int AUX_DEPTH = 2;  // Every other link buffer
    localparam bit STITCHED  = 1'b0; // Wake link kept internal when set

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic RST_FLAG = 1'b0; // Valid, wake and message flags
    localparam logic RST_RDY  = 1'b1; // Buffer ready out of reset

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [TS_TX_W-1:0]        data;
        logic [TS_TX_W/BYTE_W-1:0] keep;
        logic                      last;
        logic [TS_DEST_W-1:0]      dest;
    } dsp_ts_tx_s;

    typedef struct packed {
        logic [TS_RX_W-1:0]        data;
        logic [TS_RX_W/BYTE_W-1:0] keep;
        logic                      last;
        logic [TS_ID_W-1:0]        src;
    } dsp_ts_rx_s;

    typedef struct packed {
        logic [MSG16_W-1:0]   data;
        logic [CO_DEST_W-1:0] dest;
    } dsp_co_tx_s;

    typedef struct packed {
        logic [MSG16_W-1:0] data;
        logic [CO_ID_W-1:0] src;
    } dsp_co_rx_s;

endpackage

/* File: design/dsp_stream_ports.sv */
// Distributor stream ports: link buffer and top-level port block
`timescale 1ns/1ps

// ==========================================================
// Buffer with registered head and registered ready
// ==========================================================
module dsp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         in_vld,
    output logic              in_rdy,
    input  wire logic [W-1:0] in_dat,
    output logic              out_vld,
    input  wire logic         out_rdy,
    output logic [W-1:0]      out_dat,
    output logic              busy
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];     // Storage behind the head
    logic [AW-1:0] wr_q, wr_d;      // Write pointer
    logic [AW-1:0] rd_q, rd_d;      // Read pointer
    logic [AW:0]   cnt_q, cnt_d;    // Words in storage
    logic          ov_q, ov_d;      // Head register valid
    logic [W-1:0]  od_q, od_d;      // Head register data
    logic          rdy_q, rdy_d;    // Registered ready
    logic          push;            // Word accepted
    logic          load;            // Storage moves to head

    // Next pointers, count, head and ready
    always_comb begin
        push  = in_vld && rdy_q;
        load  = (!ov_q || out_rdy) && (cnt_q != '0);
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = load ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        ov_d  = ov_q;
        od_d  = od_q;
        if (load) begin
            // Head takes the oldest stored word
            ov_d = 1'b1;
            od_d = mem[rd_q];
        end else if (out_rdy) begin
            ov_d = 1'b0;
        end
        // Ready never promises room that is not there
        rdy_d = cnt_d < (AW+1)'(DEPTH);
    end

    // Register state; storage written on accept
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ov_q  <= dsp_pkg::RST_FLAG;
            od_q  <= '0;
            rdy_q <= dsp_pkg::RST_RDY;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_dat;
        end
    end

    assign in_rdy  = rdy_q;
    assign out_vld = ov_q;
    assign out_dat = od_q;
    assign busy    = ov_q || (cnt_q != '0);
endmodule

// Operation
// - Links valid/ready: receiver may stall by holding ready low
// - Translation-service send width fixed at build
// - Wake raised while sending or about to
// - One keep bit per payload byte
// - Destination field selects translation service
// - Inbound translation-service width fixed at build
// - Wake link: 16 bits, valid/ready only
// - Stitched build keeps wake link internal
// - Registered wake on wake-request link
// - Collator messages 16 bits with destination
// - Registered wake on collator link
module dsp_stream_ports (
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // User side, toward translation services
    input  wire logic                 ts_tx_vld,
    output logic                      ts_tx_rdy,
    input  wire dsp_pkg::dsp_ts_tx_s  ts_tx_msg,
    // Link to translation services
    output logic                      ts_o_tvalid,
    input  wire logic                 ts_o_tready,
    output dsp_pkg::dsp_ts_tx_s       ts_o_t,
    output logic                      ts_o_twakeup,
    // Link from translation services
    input  wire logic                 ts_i_tvalid,
    output logic                      ts_i_tready,
    input  wire dsp_pkg::dsp_ts_rx_s  ts_i_t,
    input  wire logic                 ts_i_twakeup,
    // User side, from translation services
    output logic                      ts_rx_vld,
    input  wire logic                 ts_rx_rdy,
    output dsp_pkg::dsp_ts_rx_s       ts_rx_msg,
    output logic                      ts_rx_wake,
    // User side, wake messages
    input  wire logic                 wk_tx_vld,
    output logic                      wk_tx_rdy,
    input  wire logic [15:0]          wk_tx_data,
    // Link to the wake-request block
    output logic                      wk_o_tvalid,
    input  wire logic                 wk_o_tready,
    output logic [15:0]               wk_o_tdata,
    output logic                      wk_o_twakeup,
    // User side, toward collators
    input  wire logic                 co_tx_vld,
    output logic                      co_tx_rdy,
    input  wire dsp_pkg::dsp_co_tx_s  co_tx_msg,
    // Link to collators
    output logic                      co_o_tvalid,
    input  wire logic                 co_o_tready,
    output dsp_pkg::dsp_co_tx_s       co_o_t,
    output logic                      co_o_twakeup,
    // Link from collators
    input  wire logic                 co_i_tvalid,
    output logic                      co_i_tready,
    input  wire dsp_pkg::dsp_co_rx_s  co_i_t,
    input  wire logic                 co_i_twakeup,
    // User side, from collators
    output logic                      co_rx_vld,
    input  wire logic                 co_rx_rdy,
    output dsp_pkg::dsp_co_rx_s       co_rx_msg,
    output logic                      co_rx_wake
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic ts_busy;          // Words queued toward translation
    logic wk_busy;          // Words queued toward wake block
    logic co_busy;          // Words queued toward collators
    logic wk_vld;           // Wake buffer head valid
    logic wk_rdy;           // Wake buffer drain
    logic [15:0] wk_dat;    // Wake buffer head data
    logic msg_q, msg_d;     // Outgoing message part sent in
    logic tw_q, tw_d;       // Translation-service wake
    logic ww_q, ww_d;       // Wake-request link wake
    logic cw_q, cw_d;       // Collator link wake
    logic rw_q, rw_d;       // Inbound translation wake copy
    logic qw_q, qw_d;       // Inbound collator wake copy

    // ==========================================================
    // Outgoing translation-service path, eight stored words plus head register
    // ==========================================================
    // Payload, keep, last and dest ride as one word
    dsp_fifo #(
        .W     ($bits(dsp_pkg::dsp_ts_tx_s)),
        .DEPTH (dsp_pkg::TX_DEPTH)
    ) u_ts_tx (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .in_vld  (ts_tx_vld),
        .in_rdy  (ts_tx_rdy),
        .in_dat  (ts_tx_msg),
        .out_vld (ts_o_tvalid),
        .out_rdy (ts_o_tready),
        .out_dat (ts_o_t),
        .busy    (ts_busy)
    );

    // ==========================================================
    // Outgoing wake-request path
    // ==========================================================
    dsp_fifo #(
        .W     (dsp_pkg::MSG16_W),
        .DEPTH (dsp_pkg::AUX_DEPTH)
    ) u_wk_tx (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .in_vld  (wk_tx_vld),
        .in_rdy  (wk_tx_rdy),
        .in_dat  (wk_tx_data),
        .out_vld (wk_vld),
        .out_rdy (wk_rdy),
        .out_dat (wk_dat),
        .busy    (wk_busy)
    );

    // Stitched build drains internally and keeps pins quiet
    assign wk_rdy      = dsp_pkg::STITCHED | wk_o_tready;
    assign wk_o_tvalid = wk_vld & ~dsp_pkg::STITCHED;
    assign wk_o_tdata  = dsp_pkg::STITCHED ? '0 : wk_dat;

    // ==========================================================
    // Outgoing collator path
    // ==========================================================
    dsp_fifo #(
        .W     ($bits(dsp_pkg::dsp_co_tx_s)),
        .DEPTH (dsp_pkg::AUX_DEPTH)
    ) u_co_tx (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .in_vld  (co_tx_vld),
        .in_rdy  (co_tx_rdy),
        .in_dat  (co_tx_msg),
        .out_vld (co_o_tvalid),
        .out_rdy (co_o_tready),
        .out_dat (co_o_t),
        .busy    (co_busy)
    );

    // ==========================================================
    // Inbound paths: ready only when a slot is free
    // ==========================================================
    // Keep and source id arrive with the word
    dsp_fifo #(
        .W     ($bits(dsp_pkg::dsp_ts_rx_s)),
        .DEPTH (dsp_pkg::AUX_DEPTH)
    ) u_ts_rx (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .in_vld  (ts_i_tvalid),
        .in_rdy  (ts_i_tready),
        .in_dat  (ts_i_t),
        .out_vld (ts_rx_vld),
        .out_rdy (ts_rx_rdy),
        .out_dat (ts_rx_msg),
        .busy    ()
    );

    // Source id comes from the system with each word
    dsp_fifo #(
        .W     ($bits(dsp_pkg::dsp_co_rx_s)),
        .DEPTH (dsp_pkg::AUX_DEPTH)
    ) u_co_rx (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .in_vld  (co_i_tvalid),
        .in_rdy  (co_i_tready),
        .in_dat  (co_i_t),
        .out_vld (co_rx_vld),
        .out_rdy (co_rx_rdy),
        .out_dat (co_rx_msg),
        .busy    ()
    );

    // ==========================================================
    // Wake generation
    // ==========================================================
    // Wake covers offered and queued words; translation wake also covers unfinished messages
    always_comb begin
        msg_d = msg_q;
        if (ts_tx_vld && ts_tx_rdy) begin
            msg_d = !ts_tx_msg.last;
        end
        tw_d = ts_tx_vld | ts_busy | msg_q;
        ww_d = (wk_tx_vld | wk_busy) & ~dsp_pkg::STITCHED;
        cw_d = co_tx_vld | co_busy;
        rw_d = ts_i_twakeup;
        qw_d = co_i_twakeup;
    end

    // Register every wake flag
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            msg_q <= dsp_pkg::RST_FLAG;
            tw_q  <= dsp_pkg::RST_FLAG;
            ww_q  <= dsp_pkg::RST_FLAG;
            cw_q  <= dsp_pkg::RST_FLAG;
            rw_q  <= dsp_pkg::RST_FLAG;
            qw_q  <= dsp_pkg::RST_FLAG;
        end else begin
            msg_q <= msg_d;
            tw_q  <= tw_d;
            ww_q  <= ww_d;
            cw_q  <= cw_d;
            rw_q  <= rw_d;
            qw_q  <= qw_d;
        end
    end

    assign ts_o_twakeup = tw_q;
    assign wk_o_twakeup = ww_q;
    assign co_o_twakeup = cw_q;
    assign ts_rx_wake   = rw_q;
    assign co_rx_wake   = qw_q;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_ts_hold_word: assert property (
        ts_o_tvalid && !ts_o_tready |=>
            ts_o_tvalid && $stable(ts_o_t))
        else $error("translation link word changed before taken");
    chk_co_hold_word: assert property (
        co_o_tvalid && !co_o_tready |=>
            co_o_tvalid && $stable(co_o_t))
        else $error("collator link word changed before taken");
    chk_ts_wake_lead: assert property (
        $rose(ts_o_tvalid) |-> ts_o_twakeup && $past(ts_o_twakeup))
        else $error("translation wake late for first valid");
    chk_ts_wake_msg: assert property (
        ts_o_tvalid |-> ts_o_twakeup)
        else $error("translation wake low during send");
    chk_ts_wake_tail: assert property (
        ts_o_tvalid && ts_o_tready && !ts_o_t.last |=> ##1 ts_o_twakeup)
        else $error("translation wake dropped mid message");
    chk_wk_wake_send: assert property (
        wk_o_tvalid |-> wk_o_twakeup)
        else $error("wake-request link wake low during send");
    chk_co_wake_send: assert property (
        co_tx_vld |=> co_o_twakeup)
        else $error("collator wake not raised on offer");
    chk_wk_link_quiet: assert property (
        dsp_pkg::STITCHED |-> !wk_o_tvalid && !wk_o_twakeup)
        else $error("stitched wake link visible");
    chk_rx_no_flood: assert property (
        !ts_i_tready && !ts_rx_rdy |=> !ts_i_tready)
        else $error("inbound ready rose while head stalled");
endmodule

/* File: test/dsp_peer_model.sv */
// Far-side model: translation service, wake-request and collator peers
`timescale 1ns/1ps
module dsp_peer_model (
    input  wire logic           sys_clk,
    input  wire logic [1:0]     mode,
    input  wire logic           ts_i_tready,
    input  wire logic           co_i_tready,
    output logic                ts_o_tready,
    output logic                wk_o_tready,
    output logic                co_o_tready,
    output logic                ts_i_tvalid,
    output dsp_pkg::dsp_ts_rx_s ts_i_t,
    output logic                ts_i_twakeup,
    output logic                co_i_tvalid,
    output dsp_pkg::dsp_co_rx_s co_i_t,
    output logic                co_i_twakeup
);
    integer seed = 92604; // Fixed seed
    integer r;            // Scratch random word
    logic [95:0] rnd;     // Random translation payload source
    logic [31:0] rco;     // Random collator payload source
    // =============================================
    // Idle state: nothing offered, sinks stalled
    // =============================================
    initial begin
        {ts_o_tready, wk_o_tready, co_o_tready} = 3'h0;
        {ts_i_tvalid, ts_i_twakeup, co_i_tvalid, co_i_twakeup} = 4'h0;
        ts_i_t = '0;
        co_i_t = '0;
    end
    // Sink ready: mode 0 stalls, 1 random, 2 always ready
    always @(posedge sys_clk) begin
        r = $random(seed);
        ts_o_tready <= mode[1] | (mode[0] & r[0]);
        wk_o_tready <= mode[1] | (mode[0] & r[1]);
        co_o_tready <= mode[1] | (mode[0] & r[2]);
    end
    // One inbound word with wake first; source added by the system
    task send_ts();
        rnd = {$random(seed), $random(seed), $random(seed)};
        @(posedge sys_clk);
        ts_i_twakeup <= 1'b1;
        @(posedge sys_clk);
        ts_i_tvalid <= 1'b1;
        ts_i_t <= rnd[74:0];
        do @(posedge sys_clk); while (ts_i_tready !== 1'b1);
        ts_i_tvalid <= 1'b0;
        ts_i_t <= ~rnd[74:0]; // Released lines no longer show the word
        ts_i_twakeup <= 1'b0;
    endtask
    // One collator word with wake first
    task send_co();
        rco = $random(seed);
        @(posedge sys_clk);
        co_i_twakeup <= 1'b1;
        @(posedge sys_clk);
        co_i_tvalid <= 1'b1;
        co_i_t <= rco[18:0];
        do @(posedge sys_clk); while (co_i_tready !== 1'b1);
        co_i_tvalid <= 1'b0;
        co_i_t <= ~rco[18:0];
        co_i_twakeup <= 1'b0;
    endtask
endmodule

/* File: test/dsp_stream_ports_tb_top.sv */
// Self-checking bench for the distributor stream ports
`timescale 1ns/1ps
module dsp_stream_ports_tb_top;
    logic sys_clk = 1'b0, rstn = 1'b0; // Clock and sync reset
    logic ts_tx_vld = 1'b0, ts_rx_rdy = 1'b0, wk_tx_vld = 1'b0;
    logic co_tx_vld = 1'b0, co_rx_rdy = 1'b0;
    logic [15:0] wk_tx_data = 16'h0000;
    dsp_pkg::dsp_ts_tx_s ts_tx_msg = '0, ts_o_t;
    dsp_pkg::dsp_co_tx_s co_tx_msg = '0, co_o_t;
    dsp_pkg::dsp_ts_rx_s ts_i_t, ts_rx_msg;
    dsp_pkg::dsp_co_rx_s co_i_t, co_rx_msg;
    logic ts_tx_rdy, ts_o_tvalid, ts_o_tready, ts_o_twakeup, ts_i_tvalid;
    logic ts_i_tready, ts_i_twakeup, ts_rx_vld, ts_rx_wake, wk_tx_rdy;
    logic wk_o_tvalid, wk_o_tready, wk_o_twakeup, co_tx_rdy, co_o_tvalid;
    logic co_o_tready, co_o_twakeup, co_i_tvalid, co_i_tready;
    logic co_i_twakeup, co_rx_vld, co_rx_wake;
    logic [15:0] wk_o_tdata;
    logic [1:0] pmode = 2'h0, rx_mode = 2'h0; // Sink modes
    logic tx_en = 1'b0, full = 1'b0;          // Offer control
    logic tsw_q = 1'b0, cow_q = 1'b0;         // Inbound wake, one late
    logic ts_open = 1'b0;                     // Message begun, no last yet
    integer seed = 92604, r, cyc = 0, fail_count = 0, checks = 0;
    integer n_ts = 0, n_wk = 0, n_co = 0, n_ti = 0, n_ci = 0;
    logic [95:0] rnd;
    dsp_pkg::dsp_ts_tx_s q_ts[$];
    dsp_pkg::dsp_co_tx_s q_co[$];
    dsp_pkg::dsp_ts_rx_s q_ti[$];
    dsp_pkg::dsp_co_rx_s q_ci[$];
    logic [15:0] q_wk[$];

    initial forever #2.5 sys_clk = ~sys_clk;

    dsp_stream_ports DUT (.sys_clk, .rstn, .ts_tx_vld, .ts_tx_rdy,
        .ts_tx_msg, .ts_o_tvalid, .ts_o_tready, .ts_o_t, .ts_o_twakeup,
        .ts_i_tvalid, .ts_i_tready, .ts_i_t, .ts_i_twakeup, .ts_rx_vld,
        .ts_rx_rdy, .ts_rx_msg, .ts_rx_wake, .wk_tx_vld, .wk_tx_rdy,
        .wk_tx_data, .wk_o_tvalid, .wk_o_tready, .wk_o_tdata,
        .wk_o_twakeup, .co_tx_vld, .co_tx_rdy, .co_tx_msg, .co_o_tvalid,
        .co_o_tready, .co_o_t, .co_o_twakeup, .co_i_tvalid, .co_i_tready,
        .co_i_t, .co_i_twakeup, .co_rx_vld, .co_rx_rdy, .co_rx_msg,
        .co_rx_wake);

    dsp_peer_model peer (.sys_clk, .mode(pmode), .ts_i_tready,
        .co_i_tready, .ts_o_tready, .wk_o_tready, .co_o_tready,
        .ts_i_tvalid, .ts_i_t, .ts_i_twakeup, .co_i_tvalid, .co_i_t,
        .co_i_twakeup);

    // =============================================
    // Compare tasks and closing report
    // =============================================
    task cmp_word(input logic [79:0] exp, input logic [79:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task cmp_bit(input logic exp, input logic got);
        cmp_word({79'h0, exp}, {79'h0, got});
    endtask
    task end_sim();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // =============================================
    // User-side offers, held until taken
    // =============================================
    always @(posedge sys_clk) begin
        r = $random(seed);
        rnd = {$random(seed), $random(seed), $random(seed)};
        if (ts_tx_vld && ts_tx_rdy) begin
            q_ts.push_back(ts_tx_msg);
            n_ts++;
            ts_open = !ts_tx_msg.last;
        end
        if (wk_tx_vld && wk_tx_rdy) begin
            q_wk.push_back(wk_tx_data);
            n_wk++;
        end
        if (co_tx_vld && co_tx_rdy) begin
            q_co.push_back(co_tx_msg);
            n_co++;
        end
        if (!ts_tx_vld || ts_tx_rdy) begin
            ts_tx_vld <= tx_en & (full | r[0]);
            ts_tx_msg <= rnd[74:0];
        end
        if (!wk_tx_vld || wk_tx_rdy) begin
            wk_tx_vld <= tx_en & (full | r[1]);
            wk_tx_data <= rnd[90:75];
        end
        if (!co_tx_vld || co_tx_rdy) begin
            co_tx_vld <= tx_en & (full | r[2]);
            co_tx_msg <= rnd[93:75];
        end
        ts_rx_rdy <= rx_mode[1] | (rx_mode[0] & r[3]);
        co_rx_rdy <= rx_mode[1] | (rx_mode[0] & r[4]);
    end

    // =============================================
    // Model against design at every transfer
    // =============================================
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            end_sim();
        end
        tsw_q <= ts_i_twakeup;
        cow_q <= co_i_twakeup;
        if (rstn) begin
            if (ts_o_tvalid && ts_o_tready)
                cmp_word(q_ts.pop_front(), ts_o_t);
            if (wk_o_tvalid && wk_o_tready)
                cmp_word(q_wk.pop_front(), wk_o_tdata);
            if (co_o_tvalid && co_o_tready)
                cmp_word(q_co.pop_front(), co_o_t);
            if (ts_i_tvalid && ts_i_tready) begin
                q_ti.push_back(ts_i_t);
                n_ti++;
            end
            if (co_i_tvalid && co_i_tready) begin
                q_ci.push_back(co_i_t);
                n_ci++;
            end
            if (ts_rx_vld && ts_rx_rdy)
                cmp_word(q_ti.pop_front(), ts_rx_msg);
            if (co_rx_vld && co_rx_rdy)
                cmp_word(q_ci.pop_front(), co_rx_msg);
            if (ts_o_tvalid) cmp_bit(1'b1, ts_o_twakeup);
            if (wk_o_tvalid) cmp_bit(1'b1, wk_o_twakeup);
            if (co_o_tvalid) cmp_bit(1'b1, co_o_twakeup);
            cmp_bit(tsw_q, ts_rx_wake);
            cmp_bit(cow_q, co_rx_wake);
        end
    end

    // =============================================
    // Main sequence: reset, fill, random, drain
    // =============================================
    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        cmp_bit(1'b1, ts_tx_rdy);
        cmp_bit(1'b1, ts_i_tready);
        cmp_bit(1'b1, wk_tx_rdy & co_tx_rdy & co_i_tready);
        cmp_bit(1'b0, ts_o_tvalid | wk_o_tvalid | co_o_tvalid);
        cmp_bit(1'b0, ts_o_twakeup | co_o_twakeup);
        cmp_word($bits(ts_o_t.data), dsp_pkg::TS_TX_W);
        cmp_word($bits(ts_i_t.data), dsp_pkg::TS_RX_W);
        cmp_word($bits(ts_o_t.keep), dsp_pkg::TS_TX_W / 8);
        cmp_word($bits(wk_o_tdata), 16);
        cmp_word($bits(co_o_t.data), 16);
        // Fill every buffer against stalled sinks until refused
        tx_en = 1'b1;
        full = 1'b1;
        fork
            repeat (44) peer.send_ts();
            repeat (44) peer.send_co();
        join_none
        repeat (40) @(posedge sys_clk);
        #1;
        cmp_word(dsp_pkg::TX_DEPTH + 1, n_ts);
        cmp_word(dsp_pkg::AUX_DEPTH + 1, n_wk);
        cmp_word(dsp_pkg::AUX_DEPTH + 1, n_co);
        cmp_word(dsp_pkg::AUX_DEPTH + 1, n_ti);
        cmp_word(dsp_pkg::AUX_DEPTH + 1, n_ci);
        cmp_bit(1'b0, ts_tx_rdy | ts_i_tready | co_i_tready);
        cmp_bit(1'b0, wk_tx_rdy | co_tx_rdy);
        // Random traffic with stalls on both sides
        full = 1'b0;
        pmode = 2'h1;
        rx_mode = 2'h1;
        repeat (1500) @(posedge sys_clk);
        #1;
        // Drain: everything delivered, wakes dropped except translation wake while a message is open
        tx_en = 1'b0;
        pmode = 2'h2;
        rx_mode = 2'h2;
        repeat (60) @(posedge sys_clk);
        #1;
        cmp_word(0, q_ts.size() + q_wk.size() + q_co.size());
        cmp_word(0, q_ti.size() + q_ci.size());
        cmp_word(44, n_ti);
        cmp_word(44, n_ci);
        cmp_bit(ts_open, ts_o_twakeup);
        cmp_bit(1'b0, wk_o_twakeup);
        cmp_bit(1'b0, co_o_twakeup | ts_rx_vld | co_rx_vld);
        end_sim();
    end
endmodule
